// ---- bench/ext_wait_ctrl_sva.sv ----
// Checker of the wait controller ports, bound into the controller
module ext_wait_ctrl_sva
   import ext_wait_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic clk_en,
   // Register bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Wait sequencing
   input wire wait_req_t wait_req,
   input wire wait_ans_t wait_ans,
   input wire logic ext_wait_n
);
   logic take, busy_q, rd_q, low4;
   logic [2:0] cnt_q;
   wait_kind_t kind_q;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // A start during a phase is dropped, so only accepted starts open a phase
   assign take = wait_req.start && clk_en && (!busy_q || wait_ans.done);
   // Shadow of the open phase and of the wait states seen in it
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         busy_q <= 1'b0;
         cnt_q <= 3'h0;
         kind_q <= K_INT_MEM;
         rd_q <= 1'b0;
      end else if (clk_en) begin
         busy_q <= take ? 1'b1 : (wait_ans.done ? 1'b0 : busy_q);
         cnt_q <= take ? 3'h0 : cnt_q + 3'(wait_ans.in_wait && cnt_q != 3'h7);
         kind_q <= take ? wait_req.kind : kind_q;
         rd_q <= hsel && hready && htrans[1] && !hwrite;
      end
   end
   // Pin low at this edge only; s_pin_held adds the three edges before it
   always_comb begin
      low4 = !ext_wait_n;
   end
   sequence s_take(wait_kind_t k);
      take && wait_req.kind == k;
   endsequence
   sequence s_pin_held;
      low4 && !$past(ext_wait_n) && !$past(ext_wait_n, 2) && !$past(ext_wait_n, 3);
   endsequence
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready and okay");
   chk_read_idle: assert property (!rd_q |-> hrdata == 32'h0)
      else $error("read data outside a read phase");
   chk_int_nowait: assert property (s_take(K_INT_MEM) |=> !wait_ans.in_wait ##1 wait_ans.done)
      else $error("internal access was stretched");
   chk_ref_ignore: assert property (s_take(K_REF_RAS_ACT) |-> ##[2:9] wait_ans.done)
      else $error("refresh phase not ended in time");
   chk_pin_extends: assert property (wait_ans.in_wait && kind_q == K_SRAM_ROM_IO ##0 s_pin_held |=> wait_ans.in_wait)
      else $error("held wait pin did not add a wait");
   chk_waits_count: assert property (wait_ans.done |-> wait_ans.waits == cnt_q)
      else $error("reported waits differ from wait states");
   chk_done_single: assert property (wait_ans.done |=> !wait_ans.done)
      else $error("done longer than one cycle");
   chk_wait_done: assert property ($fell(wait_ans.in_wait) |-> wait_ans.done)
      else $error("wait states ended without done");
endmodule : ext_wait_ctrl_sva

bind ext_wait_ctrl ext_wait_ctrl_sva i_sva (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .wait_req(wait_req), .wait_ans(wait_ans), .ext_wait_n(ext_wait_n));

// ---- bench/ext_wait_ctrl_tb.sv ----
// Testbench of the wait controller: registers, wait phases per kind, reset
module ext_wait_ctrl_tb
   import ext_wait_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; $display("[ERR] %0t mismatch", $time); end end
   typedef struct packed {
      wait_kind_t k;
      logic [2:0] b;
      logic w;
      logic o;
      logic [4:0] p;
      logic [3:0] e;
   } row_t;
   localparam logic [15:0] LO = 16'h1b4e;
   localparam logic [7:0] HI = 8'ha4;
   // Expected 8 means the block's programmed count; pin length p in cycles
   // Internal and peripheral rows follow a row that left the pin low, so the pin has already crossed the synchroniser
   localparam row_t ROWS [21] = '{
      '{K_SRAM_ROM_IO, 3'h0, 1'b0, 1'b0, 5'h0, 4'h8}, '{K_SRAM_ROM_IO, 3'h1, 1'b0, 1'b0, 5'h0, 4'h8},
      '{K_SRAM_ROM_IO, 3'h2, 1'b0, 1'b0, 5'h0, 4'h8}, '{K_SRAM_ROM_IO, 3'h3, 1'b0, 1'b0, 5'h0, 4'h8},
      '{K_SRAM_ROM_IO, 3'h4, 1'b0, 1'b0, 5'h0, 4'h8}, '{K_SRAM_ROM_IO, 3'h5, 1'b0, 1'b0, 5'h0, 4'h8},
      '{K_SRAM_ROM_IO, 3'h6, 1'b0, 1'b0, 5'h0, 4'h8}, '{K_SRAM_ROM_IO, 3'h7, 1'b0, 1'b0, 5'h0, 4'h8},
      '{K_PAGE_OFF, 3'h2, 1'b0, 1'b1, 5'h0, 4'h8}, '{K_PAGE_ON, 3'h2, 1'b0, 1'b0, 5'h0, 4'h7},
      '{K_SRAM_ROM_IO, 3'h3, 1'b0, 1'b0, 5'hc, 4'h7}, '{K_SRAM_ROM_IO, 3'h5, 1'b0, 1'b0, 5'h1, 4'h8},
      '{K_DRAM_RAS_PRE, 3'h0, 1'b0, 1'b1, 5'hc, 4'h3}, '{K_INT_MEM, 3'h1, 1'b0, 1'b0, 5'hc, 4'h0},
      '{K_PERIPH, 3'h1, 1'b0, 1'b0, 5'hc, 4'h0}, '{K_DRAM_CAS_PRE, 3'h0, 1'b0, 1'b0, 5'hc, 4'h3},
      '{K_DRAM_DATA, 3'h0, 1'b0, 1'b0, 5'hc, 4'h3}, '{K_DRAM_DATA, 3'h0, 1'b0, 1'b1, 5'hc, 4'h7},
      '{K_DRAM_ROW_HOLD, 3'h0, 1'b1, 1'b1, 5'hc, 4'h7}, '{K_REF_RAS_PRE, 3'h0, 1'b0, 1'b0, 5'hc, 4'h3},
      '{K_REF_RAS_ACT, 3'h0, 1'b0, 1'b0, 5'hc, 4'h7}};
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp, ext_wait_n;
   logic [2:0] w, e;
   logic [4:0] hold_len = 5'h0;
   logic periph_on = 1'b0;
   logic periph_wait = 1'b0;
   wait_req_t wait_req = '0;
   wait_ans_t wait_ans;
   int miscompares = 0;
   int tests_run = 0;
   int cycles = 0;
   int cy;
   always #25 clk_sys = ~clk_sys;
   ext_wait_ctrl i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .wait_req(wait_req), .wait_ans(wait_ans), .periph_wait(periph_wait),
      .ext_wait_n(ext_wait_n));
   ext_wait_device i_dev (.clk_sys(clk_sys), .arst_n(arst_n), .start(wait_req.start), .hold_len(hold_len),
      .ext_wait_n(ext_wait_n));
   // Peripheral request follows the device pin one edge late, only when enabled
   always @(posedge clk_sys) begin
      periph_wait <= periph_on & !ext_wait_n;
   end
   task automatic results();
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results
   // One single AHB-Lite transfer; the bus hready is the slave's own
   task automatic ahb(input logic wr, input logic [33:0] idx, input logic [2:0] sz, input logic [31:0] wd,
         output logic [31:0] rdv);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= sz;
      haddr <= 32'(idx << IDX_LSB);
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask : ahb
   // One wait phase; start stands one cycle, cy is the cycle of done with the first state as cycle 1
   task automatic run(input row_t r, output logic [2:0] wv, output int cyv);
      @(posedge clk_sys);
      wait_req <= '{start: 1'b1, kind: r.k, block: r.b, dram_sel: 2'h0, write: r.w, off_page: r.o};
      hold_len <= r.p;
      cyv = 0;
      @(posedge clk_sys);
      wait_req.start <= 1'b0;
      do begin
         @(negedge clk_sys);
         cyv++;
      end while (wait_ans.done !== 1'b1 && cyv < 40);
      wv = wait_ans.waits;
   endtask : run
   // Cut a hang short
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         results();
      end
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      arst_n <= 1'b1;
      // Both wait registers are set once, before any external phase; the bus carries whole words only
      ahb(1'b1, DATA_WAIT_LOW_IDX, 3'h2, {16'h0, LO}, rd);
      ahb(1'b1, DATA_WAIT_HIGH_IDX, 3'h2, {24'h0, HI}, rd);
      ahb(1'b0, DATA_WAIT_LOW_IDX, 3'h2, 32'h0, rd);
      `CHK(rd[15:0], LO)
      ahb(1'b0, DATA_WAIT_HIGH_IDX, 3'h2, 32'h0, rd);
      `CHK(rd[7:0], HI)
      for (int i = 0; i < 21; i++) begin
         e = (ROWS[i].e == 4'h8) ? {HI[ROWS[i].b], LO[2 * ROWS[i].b +: 2]} : ROWS[i].e[2:0];
         run(ROWS[i], w, cy);
         `CHK(w, e)
         if (ROWS[i].p == 5'h0 || e != 3'h7) `CHK(cy, int'(e) + 2)
         $display("row %0d done", i);
      end
      // EDO on set 0 drops the pin in the conditional data phase
      ahb(1'b1, DRAM_TYPE_IDX, 3'h2, 32'h1, rd);
      run('{K_DRAM_DATA, 3'h0, 1'b0, 1'b1, 5'hc, 4'h3}, w, cy);
      `CHK(w, 3'h3)
      `CHK(cy, 5)
      $display("edo test done");
      // On-page cycles follow their own count, not the block's
      ahb(1'b1, PAGE_ROM_WAIT_IDX, 3'h2, 32'h2, rd);
      run('{K_PAGE_ON, 3'h2, 1'b0, 1'b0, 5'h0, 4'h2}, w, cy);
      `CHK(w, 3'h2)
      `CHK(cy, 4)
      $display("page test done");
      // Peripheral asks for four waits; only it decides the length
      periph_on <= 1'b1;
      run('{K_PERIPH, 3'h1, 1'b0, 1'b0, 5'h4, 4'h0}, w, cy);
      periph_on <= 1'b0;
      `CHK(w, 3'h4)
      `CHK(cy, 6)
      $display("peripheral test done");
      // Reset in mid-run, then an unmapped write and read
      @(posedge clk_sys);
      arst_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      arst_n <= 1'b1;
      ahb(1'b1, 34'h0_ffff_f0ff, 3'h2, 32'h0, rd);
      ahb(1'b0, DATA_WAIT_LOW_IDX, 3'h2, 32'h0, rd);
      `CHK(rd[15:0], 16'hffff)
      ahb(1'b0, DATA_WAIT_HIGH_IDX, 3'h2, 32'h0, rd);
      `CHK(rd[7:0], 8'hff)
      ahb(1'b0, 34'h0_ffff_f0ff, 3'h2, 32'h0, rd);
      `CHK(rd, 32'h0)
      run('{K_SRAM_ROM_IO, 3'h5, 1'b0, 1'b0, 5'h0, 4'h7}, w, cy);
      `CHK(w, 3'h7)
      `CHK(cy, 9)
      $display("reset test done");
      results();
   end
endmodule : ext_wait_ctrl_tb

// ---- bench/ext_wait_device.sv ----
// Slow external device that stretches bus cycles through the wait pin
module ext_wait_device (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Cycle start and stretch length
   input wire logic start,
   input wire logic [4:0] hold_len,
   // Wait pin, pulled up while not driven low
   output logic ext_wait_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] left_q;
   // Falling edge keeps the pin out of step with the sampling edge
   always_ff @(negedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         left_q <= 5'h0;
      end else if (start) begin
         left_q <= hold_len;
      end else if (left_q != 5'h0) begin
         left_q <= left_q - 5'h1;
      end
   end
   // Held low for hold_len cycles, at most 31
   assign ext_wait_n = (left_q == 5'h0);
endmodule : ext_wait_device

// ---- hdl/ext_wait_ctrl.sv ----
// Wait-state controller of the external bus with its AHB-Lite register slave
module ext_wait_ctrl
   import ext_wait_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic clk_en,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Bus sequencer side
   input wire wait_req_t wait_req,
   output wait_ans_t wait_ans,
   // Peripheral wait request and external wait pin
   input wire logic periph_wait,
   input wire logic ext_wait_n
);

   typedef struct packed {
      bus_state_t st;
      logic [2:0] cnt;
      logic ext_ok;
      logic periph;
      logic sync1;
      logic sync2;
      logic [15:0] low;
      logic [7:0] high;
      logic [2:0] page_rom_wait_config;
      logic [31:0] drc;
      logic [3:0] edo;
      logic [4:0] refresh_wait_config;
      logic ap_valid;
      logic ap_write;
      logic ap_wide;
      logic [1:0] ap_lane;
      logic [IDX_BITS-1:0] ap_idx;
      logic in_wait;
      logic done;
      logic [2:0] waits;
      logic [7:0] done_cnt;
   } ctl_t;

   localparam logic [IDX_BITS-1:0] LOW_I = DATA_WAIT_LOW_IDX[IDX_BITS-1:0];
   localparam logic [IDX_BITS-1:0] HIGH_I = DATA_WAIT_HIGH_IDX[IDX_BITS-1:0];
   localparam logic [IDX_BITS-1:0] PRC_I = PAGE_ROM_WAIT_IDX[IDX_BITS-1:0];
   localparam logic [IDX_BITS-1:0] DRC_I = DRAM_TIMING_IDX[IDX_BITS-1:0];
   localparam logic [IDX_BITS-1:0] RWC_I = REFRESH_WAIT_IDX[IDX_BITS-1:0];
   localparam logic [IDX_BITS-1:0] EDO_I = DRAM_TYPE_IDX[IDX_BITS-1:0];
   localparam logic [IDX_BITS-1:0] STAT_I = WAIT_STATUS_IDX[IDX_BITS-1:0];

   ctl_t s_q;
   ctl_t s_d;
   logic [2:0] blk_cnt;
   logic [7:0] drc_byte;
   logic [2:0] sel_cnt;
   logic sel_ext;
   logic sel_periph;
   logic ext_req;
   logic more;
   logic [15:0] wdat;

   // Per-block data wait count from the split registers
   always_comb begin
      blk_cnt = {s_q.high[wait_req.block],
                 s_q.low[{wait_req.block, 1'b1}],
                 s_q.low[{wait_req.block, 1'b0}]};
      drc_byte = s_q.drc[{wait_req.dram_sel, 3'b000} +: 8];
   end

   // Count, pin honouring and peripheral selection by cycle type
   always_comb begin
      sel_cnt = 3'h0;
      sel_ext = 1'b0;
      sel_periph = 1'b0;
      case (wait_req.kind)
         K_INT_MEM: begin
            sel_cnt = 3'h0;
         end
         K_PERIPH: begin
            sel_periph = 1'b1;
         end
         K_SRAM_ROM_IO, K_PAGE_OFF: begin
            sel_cnt = blk_cnt;
            sel_ext = 1'b1;
         end
         K_PAGE_ON: begin
            sel_cnt = s_q.page_rom_wait_config;
            sel_ext = 1'b1;
         end
         K_DRAM_RAS_PRE: begin
            sel_cnt = {1'b0, drc_byte[DRAM_RAS_PRE_LSB +: 2]};
         end
         K_DRAM_ROW_HOLD: begin
            sel_cnt = {1'b0, drc_byte[DRAM_ROW_HOLD_LSB +: 2]};
            sel_ext = wait_req.write & wait_req.off_page & ~s_q.edo[wait_req.dram_sel];
         end
         K_DRAM_CAS_PRE: begin
            sel_cnt = {1'b0, drc_byte[DRAM_CAS_PRE_LSB +: 2]};
         end
         K_DRAM_DATA: begin
            sel_cnt = {1'b0, drc_byte[DRAM_DATA_LSB +: 2]};
            sel_ext = ~wait_req.write & wait_req.off_page & ~s_q.edo[wait_req.dram_sel];
         end
         K_REF_RAS_PRE: begin
            sel_cnt = {1'b0, s_q.refresh_wait_config[REF_RAS_PRE_LSB +: 2]};
         end
         K_REF_RAS_ACT: begin
            sel_cnt = s_q.refresh_wait_config[REF_RAS_ACT_LSB +: 3];
         end
         default: begin
            sel_cnt = 3'h0;
         end
      endcase
   end

   // Pin wait is only looked at in the first state and wait states of an honouring cycle
   assign ext_req = s_q.ext_ok & ~s_q.sync2;
   // Programmed waits OR pin waits, so the longer of the two wins
   assign more = s_q.periph ? periph_wait : ((s_q.cnt != 3'h0) | ext_req);
   assign wdat = s_q.ap_lane[1] ? hwdata[31:16] : hwdata[15:0];

   // Next state of the whole block
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      // Two flops on the asynchronous pin; only the second one is read
      s_d.sync1 = ext_wait_n;
      s_d.sync2 = s_q.sync1;
      case (s_q.st)
         ST_IDLE: begin
            s_d.in_wait = 1'b0;
            if (wait_req.start) begin
               s_d.st = ST_FIRST;
               s_d.cnt = sel_cnt;
               s_d.ext_ok = sel_ext;
               s_d.periph = sel_periph;
               s_d.waits = 3'h0;
            end
         end
         ST_FIRST, ST_WAIT: begin
            if (more) begin
               // Another wait state; the pin can hold the cycle indefinitely
               s_d.st = ST_WAIT;
               s_d.in_wait = 1'b1;
               s_d.cnt = (s_q.cnt != 3'h0) ? s_q.cnt - 3'h1 : 3'h0;
               s_d.waits = (s_q.waits != 3'h7) ? s_q.waits + 3'h1 : s_q.waits;
            end else begin
               s_d.st = ST_IDLE;
               s_d.in_wait = 1'b0;
               s_d.done = 1'b1;
               s_d.ext_ok = 1'b0;
               s_d.periph = 1'b0;
               s_d.done_cnt = s_q.done_cnt + 8'h01;
            end
         end
         default: begin
            s_d.st = ST_IDLE;
         end
      endcase

      // AHB data phase write; narrow writes to the low register are dropped
      if (s_q.ap_valid && s_q.ap_write) begin
         case (s_q.ap_idx)
            LOW_I: begin
               if (s_q.ap_wide && !s_q.ap_lane[0]) begin
                  s_d.low = wdat;
               end
            end
            HIGH_I: begin
               if (s_q.ap_lane == 2'b00) begin
                  s_d.high = hwdata[7:0];
               end
            end
            PRC_I: begin
               s_d.page_rom_wait_config = hwdata[2:0];
            end
            DRC_I: begin
               s_d.drc = hwdata;
            end
            RWC_I: begin
               s_d.refresh_wait_config = hwdata[4:0];
            end
            EDO_I: begin
               s_d.edo = hwdata[3:0];
            end
            default: begin
               s_d.page_rom_wait_config = s_q.page_rom_wait_config;
            end
         endcase
      end

      // AHB address phase capture
      if (hready) begin
         s_d.ap_valid = hsel & htrans[1];
         s_d.ap_write = hwrite;
         s_d.ap_wide = (hsize >= HSIZE_HALF);
         s_d.ap_lane = haddr[1:0];
         s_d.ap_idx = haddr[IDX_LSB +: IDX_BITS];
      end
   end

   // State register; clock enable freezes everything
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
         s_q.st <= ST_IDLE;
         s_q.sync1 <= 1'b1;
         s_q.sync2 <= 1'b1;
         s_q.low <= DATA_WAIT_LOW_RST;
         s_q.high <= DATA_WAIT_HIGH_RST;
         s_q.page_rom_wait_config <= PAGE_ROM_WAIT_RST;
         s_q.drc <= DRAM_TIMING_RST;
         s_q.refresh_wait_config <= REFRESH_WAIT_RST;
         s_q.edo <= DRAM_TYPE_RST;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // Read mux over flops, answered in the data phase with no wait
   always_comb begin
      hrdata = 32'h0;
      if (s_q.ap_valid && !s_q.ap_write) begin
         case (s_q.ap_idx)
            LOW_I: hrdata = {16'h0, s_q.low};
            HIGH_I: hrdata = {24'h0, s_q.high};
            PRC_I: hrdata = {29'h0, s_q.page_rom_wait_config};
            DRC_I: hrdata = s_q.drc;
            RWC_I: hrdata = {27'h0, s_q.refresh_wait_config};
            EDO_I: hrdata = {28'h0, s_q.edo};
            STAT_I: begin
               hrdata[STAT_STATE_LSB +: 2] = s_q.st;
               hrdata[STAT_CNT_LSB +: 3] = s_q.cnt;
               hrdata[STAT_EXT_BIT] = s_q.sync2;
               hrdata[STAT_DONE_LSB +: 8] = s_q.done_cnt;
            end
            default: hrdata = 32'h0;
         endcase
      end
   end

   // Zero-wait OKAY slave
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Answer to the sequencer straight from flops
   assign wait_ans.in_wait = s_q.in_wait;
   assign wait_ans.done = s_q.done;
   assign wait_ans.waits = s_q.waits;

endmodule : ext_wait_ctrl

// ---- include/ext_wait_pkg.sv ----
// Package: register map, field layout, reset values and carriers of the wait controller
package ext_wait_pkg;

   // Register indices; byte address is four times the index
   localparam logic [33:0] DATA_WAIT_LOW_IDX = 34'h0_ffff_f060;
   localparam logic [33:0] DATA_WAIT_HIGH_IDX = 34'h0_ffff_f06a;
   localparam logic [33:0] PAGE_ROM_WAIT_IDX = 34'h0_ffff_f070;
   localparam logic [33:0] DRAM_TIMING_IDX = 34'h0_ffff_f071;
   localparam logic [33:0] REFRESH_WAIT_IDX = 34'h0_ffff_f072;
   localparam logic [33:0] DRAM_TYPE_IDX = 34'h0_ffff_f073;
   localparam logic [33:0] WAIT_STATUS_IDX = 34'h0_ffff_f074;
   localparam int IDX_LSB = 2;
   localparam int IDX_BITS = 10;

   // Reset values
   localparam logic [15:0] DATA_WAIT_LOW_RST = 16'hffff;
   localparam logic [7:0] DATA_WAIT_HIGH_RST = 8'hff;
   localparam logic [2:0] PAGE_ROM_WAIT_RST = 3'h7;
   localparam logic [31:0] DRAM_TIMING_RST = 32'hffff_ffff;
   localparam logic [4:0] REFRESH_WAIT_RST = 5'h1f;
   localparam logic [3:0] DRAM_TYPE_RST = 4'h0;

   // Field positions inside one byte of the DRAM timing register
   localparam int DRAM_RAS_PRE_LSB = 0;
   localparam int DRAM_ROW_HOLD_LSB = 2;
   localparam int DRAM_CAS_PRE_LSB = 4;
   localparam int DRAM_DATA_LSB = 6;
   // Field positions inside the refresh register
   localparam int REF_RAS_PRE_LSB = 0;
   localparam int REF_RAS_ACT_LSB = 2;
   // Field positions inside the status register
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_CNT_LSB = 2;
   localparam int STAT_EXT_BIT = 5;
   localparam int STAT_DONE_LSB = 8;

   // AHB encodings
   localparam logic [2:0] HSIZE_HALF = 3'h1;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FIRST = 2'b01,
      ST_WAIT = 2'b10
   } bus_state_t;

   typedef enum logic [3:0] {
      K_INT_MEM = 4'b0000,
      K_PERIPH = 4'b0001,
      K_SRAM_ROM_IO = 4'b0010,
      K_PAGE_OFF = 4'b0011,
      K_PAGE_ON = 4'b0100,
      K_DRAM_RAS_PRE = 4'b0101,
      K_DRAM_ROW_HOLD = 4'b0110,
      K_DRAM_CAS_PRE = 4'b0111,
      K_DRAM_DATA = 4'b1000,
      K_REF_RAS_PRE = 4'b1001,
      K_REF_RAS_ACT = 4'b1010
   } wait_kind_t;

   // Request from the bus sequencer for one wait phase
   typedef struct packed {
      logic start;
      wait_kind_t kind;
      logic [2:0] block;
      logic [1:0] dram_sel;
      logic write;
      logic off_page;
   } wait_req_t;

   // Answer to the bus sequencer
   typedef struct packed {
      logic in_wait;
      logic done;
      logic [2:0] waits;
   } wait_ans_t;

endpackage : ext_wait_pkg
